// ---- pec_error_capture.sv ----
// Contract
// - Code zero means nothing held, fields clear.
// - Bad select ID on config store: code 1.
// - Request ID out of range: code 2.
// - Bad monitor ID or group: code 3.
// - Request group out of range: code 4.
// - Monitor selector out of range: code 5.
// - Narrowing map or internal flag faults: code 6.
// - Internal flag set on map access: code 7.
// - Codes 6 and 7 need narrowing present.
// - Codes 8 to 15 never recorded by hardware; a software write can store them.
// - Instance chosen by request or address security.
// - Bad request ID mapped to default ID.
// - Bad group uses default, excluded from counting.
// - Read causing code 7 returns undefined data.
// - Overwrite of nonzero code sets overwritten flag.
// - Errors overwrite the syndrome; a same-cycle config error beats a request one.
// - Hardware never makes flag one, code zero.
// - Flag 31, code 27:24, group 23:16, ID 15:0.
// - Uncaptured group and ID fields written zero.
// - Interrupt raised only when its enable is one.
// - Errors never block request handling.
`timescale 1ns/1ps
`include "pec_consts.svh"

module pec_error_capture #(
   parameter int PID_W = 16,
   parameter int GRP_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [15:0]       pid_max_s,
   input  wire logic [15:0]       pid_max_ns,
   input  wire logic [7:0]        grp_max_s,
   input  wire logic [7:0]        grp_max_ns,
   input  wire logic [15:0]       mon_max,
   input  wire logic [15:0]       nrw_pid_max_s,
   input  wire logic [15:0]       nrw_pid_max_ns,
   input  wire logic              narrowing_present,
   input  wire pec_pkg::pec_req_t req_in,
   input  wire pec_pkg::pec_cfg_t cfg_in,
   input  wire logic              sw_esr_wr_s,
   input  wire logic              sw_esr_wr_ns,
   input  wire logic [31:0]       sw_esr_wdata,
   input  wire logic              error_irq_enable_s,
   input  wire logic              error_irq_enable_ns,
   output pec_pkg::pec_req_t      req_out,
   output logic                   req_mon_exclude,
   output logic                   cfg_rdata_undefined,
   output logic [31:0]            error_status_register_s,
   output logic [31:0]            error_status_register_ns,
   output logic                   err_irq_s,
   output logic                   err_irq_ns
);

   initial begin
      if (PID_W != 16 || GRP_W != 8) begin
         $error("pec_error_capture: ID widths must be 16 and 8");
      end
   end

   pec_pkg::pec_err_t req_err;
   pec_pkg::pec_err_t cfg_err;
   pec_pkg::pec_req_t req_nxt;
   logic              excl_nxt;
   logic              undef_nxt;
   logic [31:0]       esr_s_r;
   logic [31:0]       esr_ns_r;
   logic [31:0]       esr_s_nxt;
   logic [31:0]       esr_ns_nxt;
   pec_pkg::pec_req_t req_r;
   logic              excl_r;
   logic              undef_r;

   function automatic logic [31:0] pec_pack(input logic [3:0]  code,
                                            input logic [7:0]  grp,
                                            input logic [15:0] id);
      logic [31:0] v;
      v = `PEC_ESR_RESET;
      v[`PEC_CODE_HI:`PEC_CODE_LO] = code;
      v[`PEC_GRP_HI:`PEC_GRP_LO]   = grp;
      v[`PEC_ID_HI:`PEC_ID_LO]     = id;
      return v;
   endfunction : pec_pack

   // Request-side checks; the request is always forwarded, possibly remapped.
   always_comb begin
      logic        pid_bad;
      logic        grp_bad;
      logic [15:0] pmax;
      logic [7:0]  gmax;
      pmax      = req_in.ns ? pid_max_ns : pid_max_s;
      gmax      = req_in.ns ? grp_max_ns : grp_max_s;
      pid_bad   = req_in.pid > pmax;
      grp_bad   = req_in.grp > gmax;
      req_err   = '0;
      req_err.ns = req_in.ns;
      req_err.id  = req_in.pid;
      req_err.grp = req_in.grp;
      req_nxt   = req_in;
      excl_nxt  = 1'b0;
      if (req_in.valid && pid_bad) begin
         req_err.valid = 1'b1;
         req_err.code  = `PEC_CODE_REQ_PID;
         req_nxt.pid   = `PEC_DEF_PID;
      end else if (req_in.valid && grp_bad) begin
         req_err.valid = 1'b1;
         req_err.code  = `PEC_CODE_REQ_GRP;
         req_nxt.grp   = `PEC_DEF_GRP;
         excl_nxt      = 1'b1;
      end
   end

   // Configuration checks, highest priority first; one syndrome per access.
   always_comb begin
      logic [15:0] pmax;
      logic [7:0]  gmax;
      logic [15:0] nmax;
      pmax       = cfg_in.ns ? pid_max_ns : pid_max_s;
      gmax       = cfg_in.ns ? grp_max_ns : grp_max_s;
      nmax       = cfg_in.ns ? nrw_pid_max_ns : nrw_pid_max_s;
      cfg_err    = '0;
      cfg_err.ns = cfg_in.ns;
      undef_nxt  = 1'b0;
      if (cfg_in.psel_store && cfg_in.psel_pid > pmax) begin
         cfg_err.valid = 1'b1;
         cfg_err.code  = `PEC_CODE_PSEL_RANGE;
         cfg_err.id    = cfg_in.psel_pid;
         cfg_err.grp   = `PEC_GRP_ZERO;
      end else if ((cfg_in.mon_cfg_store || cfg_in.monitor_selector_store) &&
                   cfg_in.monitor_selector > mon_max) begin
         cfg_err.valid = 1'b1;
         cfg_err.code  = `PEC_CODE_MON_RANGE;
         cfg_err.id    = cfg_in.monitor_selector;
         cfg_err.grp   = `PEC_GRP_ZERO;
      end else if (cfg_in.mon_cfg_store &&
                   (cfg_in.mon_pid > pmax || cfg_in.mon_grp > gmax)) begin
         cfg_err.valid = 1'b1;
         cfg_err.code  = `PEC_CODE_MON_ID;
         cfg_err.id    = cfg_in.mon_pid;
         cfg_err.grp   = cfg_in.mon_grp;
      end else if (narrowing_present && cfg_in.nrw_access && cfg_in.psel_internal) begin
         cfg_err.valid = 1'b1;
         cfg_err.code  = `PEC_CODE_UNEXP_INT;
         cfg_err.id    = cfg_in.psel_pid;
         cfg_err.grp   = `PEC_GRP_ZERO;
         undef_nxt     = cfg_in.read;
      end else if (narrowing_present &&
                   ((cfg_in.nrw_write &&
                     (cfg_in.nrw_pid > nmax || !cfg_in.nrw_internal)) ||
                    (cfg_in.other_cfg_access && !cfg_in.psel_internal))) begin
         cfg_err.valid = 1'b1;
         cfg_err.code  = `PEC_CODE_NRW_RANGE;
         cfg_err.id    = cfg_in.nrw_write ? cfg_in.nrw_pid : cfg_in.psel_pid;
         cfg_err.grp   = `PEC_GRP_ZERO;
      end
   end

   function automatic logic [31:0] pec_update(input logic [31:0]       cur,
                                              input logic              sw_wr,
                                              input logic [31:0]       sw_d,
                                              input pec_pkg::pec_err_t e0,
                                              input pec_pkg::pec_err_t e1,
                                              input logic              mine_ns);
      logic [31:0] v;
      logic        h0;
      logic        h1;
      logic        ovr;
      v   = sw_wr ? sw_d : cur;
      h0  = e0.valid && (e0.ns == mine_ns);
      h1  = e1.valid && (e1.ns == mine_ns);
      ovr = v[`PEC_OVR_BIT];
      // Hardware errors win over a same-cycle software write.
      if (h0 && h1) begin
         ovr = 1'b1;
         v   = pec_pack(e1.code, e1.grp, e1.id);
      end else if (h0 || h1) begin
         ovr = ovr || (v[`PEC_CODE_HI:`PEC_CODE_LO] != `PEC_CODE_NONE);
         v   = h1 ? pec_pack(e1.code, e1.grp, e1.id)
                  : pec_pack(e0.code, e0.grp, e0.id);
      end
      v[`PEC_OVR_BIT] = ovr;
      return v;
   endfunction : pec_update

   always_comb begin
      esr_s_nxt  = pec_update(esr_s_r, sw_esr_wr_s, sw_esr_wdata, req_err, cfg_err, 1'b0);
      esr_ns_nxt = pec_update(esr_ns_r, sw_esr_wr_ns, sw_esr_wdata, req_err, cfg_err, 1'b1);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         esr_s_r  <= `PEC_ESR_RESET;
         esr_ns_r <= `PEC_ESR_RESET;
         req_r    <= '0;
         excl_r   <= 1'b0;
         undef_r  <= 1'b0;
      end else begin
         esr_s_r  <= esr_s_nxt;
         esr_ns_r <= esr_ns_nxt;
         req_r    <= req_nxt;
         excl_r   <= excl_nxt;
         undef_r  <= undef_nxt;
      end
   end

   assign error_status_register_s  = esr_s_r;
   assign error_status_register_ns = esr_ns_r;
   assign req_out                  = req_r;
   assign req_mon_exclude          = excl_r;
   assign cfg_rdata_undefined      = undef_r;
   // Hardware cannot raise codes 8..15: only named constants are ever packed.
   assign err_irq_s  = error_irq_enable_s &&
                       (esr_s_r[`PEC_CODE_HI:`PEC_CODE_LO] != `PEC_CODE_NONE);
   assign err_irq_ns = error_irq_enable_ns &&
                       (esr_ns_r[`PEC_CODE_HI:`PEC_CODE_LO] != `PEC_CODE_NONE);

endmodule : pec_error_capture

// ---- pec_consts.svh ----
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH
`define PEC_CODE_NONE       4'h0
`define PEC_CODE_PSEL_RANGE 4'h1
`define PEC_CODE_REQ_PID    4'h2
`define PEC_CODE_MON_ID     4'h3
`define PEC_CODE_REQ_GRP    4'h4
`define PEC_CODE_MON_RANGE  4'h5
`define PEC_CODE_NRW_RANGE  4'h6
`define PEC_CODE_UNEXP_INT  4'h7
`define PEC_OVR_BIT         31
`define PEC_CODE_HI         27
`define PEC_CODE_LO         24
`define PEC_GRP_HI          23
`define PEC_GRP_LO          16
`define PEC_ID_HI           15
`define PEC_ID_LO           0
`define PEC_GRP_ZERO        8'h00
`define PEC_ID_ZERO         16'h0000
`define PEC_DEF_PID         16'h0000
`define PEC_DEF_GRP         8'h00
`define PEC_ESR_RESET       32'h0000_0000
`endif

// ---- pec_pkg.sv ----
package pec_pkg;
   typedef struct packed {
      logic        valid;
      logic        ns;
      logic [15:0] pid;
      logic [7:0]  grp;
   } pec_req_t;

   typedef struct packed {
      logic        valid;
      logic        ns;
      logic [3:0]  code;
      logic [7:0]  grp;
      logic [15:0] id;
   } pec_err_t;

   typedef struct packed {
      logic        psel_store;
      logic        mon_cfg_store;
      logic        monitor_selector_store;
      logic        nrw_access;
      logic        nrw_write;
      logic        other_cfg_access;
      logic        read;
      logic        ns;
      logic [15:0] psel_pid;
      logic        psel_internal;
      logic [15:0] monitor_selector;
      logic [15:0] mon_pid;
      logic [7:0]  mon_grp;
      logic [15:0] nrw_pid;
      logic        nrw_internal;
   } pec_cfg_t;

   typedef enum logic [1:0] {
      PEC_IDLE = 2'b01,
      PEC_HELD = 2'b10
   } pec_state_t;
endpackage : pec_pkg

// ---- pec_error_capture_asserts.sv ----
`timescale 1ns/1ps
module pec_error_capture_asserts (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic [15:0]       pid_max_s,
   input wire logic [15:0]       pid_max_ns,
   input wire logic [7:0]        grp_max_s,
   input wire logic              narrowing_present,
   input wire pec_pkg::pec_req_t req_in,
   input wire pec_pkg::pec_cfg_t cfg_in,
   input wire logic              sw_esr_wr_s,
   input wire logic              sw_esr_wr_ns,
   input wire logic              error_irq_enable_s,
   input wire pec_pkg::pec_req_t req_out,
   input wire logic              req_mon_exclude,
   input wire logic              cfg_rdata_undefined,
   input wire logic [31:0]       error_status_register_s,
   input wire logic [31:0]       error_status_register_ns,
   input wire logic              err_irq_s
);
   logic cq;
   logic bad_ns;
   // A quiet config port keeps a request error alone in its cycle.
   assign cq = !(cfg_in.psel_store || cfg_in.mon_cfg_store || cfg_in.monitor_selector_store
                 || cfg_in.nrw_access || cfg_in.nrw_write || cfg_in.other_cfg_access);
   assign bad_ns = req_in.valid && req_in.ns && req_in.pid > pid_max_ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_req_pid;
      bad_ns && cq && !sw_esr_wr_ns |=> error_status_register_ns[27:0]
         == {4'h2, $past(req_in.grp), $past(req_in.pid)};
   endproperty
   a_req_pid: assert property (p_req_pid) else $error("request id syndrome wrong");
   property p_req_zero;
      bad_ns |=> req_out.valid && req_out.pid == 16'h0000;
   endproperty
   a_req_zero: assert property (p_req_zero) else $error("bad request not defaulted");
   property p_req_grp;
      req_in.valid && !req_in.ns && req_in.pid <= pid_max_s && req_in.grp > grp_max_s
         && cq && !sw_esr_wr_s |=> error_status_register_s[27:24] == 4'h4 && req_mon_exclude;
   endproperty
   a_req_grp: assert property (p_req_grp) else $error("group error not handled");
   property p_ovr;
      bad_ns && error_status_register_ns[27:24] != 4'h0 && !sw_esr_wr_ns
         |=> error_status_register_ns[31];
   endproperty
   a_ovr: assert property (p_ovr) else $error("overwritten flag not set");
   property p_sep;
      bad_ns && cq && !sw_esr_wr_s |=> $stable(error_status_register_s);
   endproperty
   a_sep: assert property (p_sep) else $error("wrong status instance touched");
   property p_irq;
      err_irq_s == (error_irq_enable_s && error_status_register_s[27:24] != 4'h0);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt does not follow enable");
   property p_hw_code;
      $changed(error_status_register_s) && !$past(sw_esr_wr_s) && $past(rst_n)
         |-> error_status_register_s[27:24] inside {[4'h1:4'h7]};
   endproperty
   a_hw_code: assert property (p_hw_code) else $error("hardware wrote bad code");
   property p_undef;
      cfg_in.read && cfg_in.nrw_access && cfg_in.psel_internal && narrowing_present
         && !cfg_in.psel_store && !cfg_in.mon_cfg_store && !cfg_in.monitor_selector_store
         |=> cfg_rdata_undefined;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined read not flagged");
   property p_no_nrw;
      !narrowing_present |=> !cfg_rdata_undefined;
   endproperty
   a_no_nrw: assert property (p_no_nrw) else $error("code 7 without narrowing");
   c_bad_ns: cover property (bad_ns && cq);
   c_undef: cover property (cfg_rdata_undefined);
   c_ovr: cover property ($rose(error_status_register_ns[31]));
endmodule : pec_error_capture_asserts

bind pec_error_capture pec_error_capture_asserts pec_error_capture_asserts_i (.clk, .rst_n,
   .pid_max_s, .pid_max_ns, .grp_max_s, .narrowing_present, .req_in, .cfg_in, .sw_esr_wr_s,
   .sw_esr_wr_ns, .error_irq_enable_s, .req_out, .req_mon_exclude, .cfg_rdata_undefined,
   .error_status_register_s, .error_status_register_ns, .err_irq_s);

// ---- pec_far_end.sv ----
`timescale 1ns/1ps
module pec_far_end (
   input wire logic              clk,
   input wire pec_pkg::pec_req_t req_cmd,
   input wire pec_pkg::pec_cfg_t cfg_cmd,
   output pec_pkg::pec_req_t     req_in,
   output pec_pkg::pec_cfg_t     cfg_in
);
   logic [23:0] last = 24'h000000;
   always @(posedge clk) begin
      if (req_cmd.valid) last <= {req_cmd.pid, req_cmd.grp};
   end
   // Idle request fields show the inverse of the last ones, so stale data cannot pass.
   always_comb begin
      req_in = req_cmd;
      if (!req_cmd.valid) {req_in.pid, req_in.grp} = ~last;
   end
   assign cfg_in = cfg_cmd;
endmodule : pec_far_end

// ---- pec_error_capture_tb.sv ----
`timescale 1ns/1ps
module pec_error_capture_tb;
   logic              clk = 1'b0, rst_n = 1'b0, np = 1'b1, sw_s = 1'b0, sw_ns = 1'b0;
   logic              excl, undef, irq_s, irq_ns, ex = 1'b0, eu = 1'b0, bp, bg;
   logic [1:0]        ien = 2'b00;
   logic [15:0]       pms = 16'h0010, pmn = 16'h0020, mm = 16'h0008, nms = 16'h0004;
   logic [15:0]       nmn = 16'h0006;
   logic [7:0]        gms = 8'h03, gmn = 8'h07;
   logic [31:0]       esr_s, esr_ns, r;
   logic [31:0]       m [0:1] = '{32'h0, 32'h0};
   pec_pkg::pec_req_t rc = '0, er = '0, req_in, req_out;
   pec_pkg::pec_cfg_t cc = '0, cfg_in;
   integer            fails = 0, n_tests = 0, seed = 32'h8b00, k, i;
   pec_far_end pec_far_end_i (.clk(clk), .req_cmd(rc), .cfg_cmd(cc), .req_in(req_in),
      .cfg_in(cfg_in));
   pec_error_capture pec_error_capture_i (.clk(clk), .rst_n(rst_n), .pid_max_s(pms),
      .pid_max_ns(pmn), .grp_max_s(gms), .grp_max_ns(gmn), .mon_max(mm), .nrw_pid_max_s(nms),
      .nrw_pid_max_ns(nmn), .narrowing_present(np), .req_in(req_in), .cfg_in(cfg_in),
      .sw_esr_wr_s(sw_s), .sw_esr_wr_ns(sw_ns), .sw_esr_wdata(32'h0000_0000),
      .error_irq_enable_s(ien[0]), .error_irq_enable_ns(ien[1]), .req_out(req_out),
      .req_mon_exclude(excl), .cfg_rdata_undefined(undef), .error_status_register_s(esr_s),
      .error_status_register_ns(esr_ns), .err_irq_s(irq_s), .err_irq_ns(irq_ns));
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic upd(input logic ns, input logic [27:0] syn);
      if (syn[27:24] != 4'h0) m[ns] = {m[ns][27:24] != 4'h0, 3'b000, syn};
   endtask : upd
   function automatic logic [27:0] cfg_syn(input pec_pkg::pec_cfg_t c);
      logic [15:0] pm;
      logic [15:0] nm;
      pm = c.ns ? pmn : pms;
      nm = c.ns ? nmn : nms;
      if (c.psel_store && c.psel_pid > pm) return {4'h1, 8'h00, c.psel_pid};
      if (c.mon_cfg_store && c.monitor_selector > mm) return {4'h5, 8'h00, c.monitor_selector};
      if (c.mon_cfg_store && (c.mon_pid > pm || c.mon_grp > (c.ns ? gmn : gms)))
         return {4'h3, c.mon_grp, c.mon_pid};
      if (!np) return 28'h0;
      if (c.nrw_access && c.psel_internal) return {4'h7, 8'h00, c.psel_pid};
      if (c.nrw_write && (c.nrw_pid > nm || !c.nrw_internal))
         return {4'h6, 8'h00, c.nrw_pid};
      if (c.other_cfg_access && !c.psel_internal) return {4'h6, 8'h00, c.psel_pid};
      return 28'h0;
   endfunction : cfg_syn
   task end_of_test;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      #(1300 * 8);
      fails++;
      end_of_test;
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (i = 0; i < 600; i++) begin
         @(negedge clk);
         chk(esr_s, m[0]);
         chk(esr_ns, m[1]);
         chk(er.valid ? {4'h0, req_out, excl, undef}
                      : {4'h0, req_out.valid, 25'h0, excl, undef},
             {4'h0, er, ex, eu});
         chk({30'h0, irq_s, irq_ns}, {30'h0, ien[0] && m[0][27:24] != 4'h0,
             ien[1] && m[1][27:24] != 4'h0});
         if (i % 150 == 0) begin
            // Fresh limits each phase move the range edges under the same traffic.
            pms = 16'h0008 + 16'($random(seed) & 32'hf);
            pmn = 16'h0008 + 16'($random(seed) & 32'hf);
            gms = 8'h02 + 8'($random(seed) & 32'h7);
            mm = 16'h0004 + 16'($random(seed) & 32'h7);
            nmn = 16'h0002 + 16'($random(seed) & 32'h7);
            np = i[7];
            ien = 2'(i / 150);
         end
         k = $random(seed) & 32'h7;
         r = $random(seed);
         rc = '0;
         cc = '0;
         {sw_s, sw_ns, ex, eu} = 4'h0;
         er = '0;
         if (k < 3) begin
            rc = '{valid: 1'b1, ns: r[0], pid: {10'h0, r[6:1]}, grp: {3'h0, r[11:7]}};
            bp = rc.pid > (rc.ns ? pmn : pms);
            bg = rc.grp > (rc.ns ? gmn : gms);
            er = rc;
            if (bp) er.pid = 16'h0000;
            if (!bp && bg) er.grp = 8'h00;
            ex = !bp && bg;
            upd(rc.ns, {bp ? 4'h2 : (bg ? 4'h4 : 4'h0), rc.grp, rc.pid});
         end else if (k == 7) begin
            sw_ns = r[0];
            sw_s = !r[0];
            m[r[0]] = 32'h0;
         end else begin
            {cc.ns, cc.psel_internal, cc.nrw_internal} = r[2:0];
            cc.read = r[3] && k > 4;
            cc.psel_pid = {10'h0, r[9:4]};
            cc.monitor_selector = {12'h0, r[13:10]};
            cc.mon_pid = {10'h0, r[19:14]};
            cc.mon_grp = {4'h0, r[23:20]};
            cc.nrw_pid = {12'h0, r[27:24]};
            case (k)
               3: cc.psel_store = 1'b1;
               4: cc.mon_cfg_store = 1'b1;
               5: {cc.nrw_access, cc.nrw_write} = {1'b1, !cc.read};
               default: cc.other_cfg_access = 1'b1;
            endcase
            upd(cc.ns, cfg_syn(cc));
            eu = cc.read && cfg_syn(cc) >> 24 == 28'h7;
         end
      end
      end_of_test;
   end
endmodule : pec_error_capture_tb
